// file: design/ddrcd_defines.vh
`ifndef DDRCD_DEFINES_VH
`define DDRCD_DEFINES_VH

// ****************************************************************
// Command codes {cs_n, ras_n, cas_n, we_n}
// ****************************************************************
`define DDRCD_CMD_LMR     4'h0
`define DDRCD_CMD_REF     4'h1
`define DDRCD_CMD_PRE     4'h2
`define DDRCD_CMD_ACT     4'h3
`define DDRCD_CMD_WR      4'h4
`define DDRCD_CMD_RD      4'h5
`define DDRCD_CMD_BST     4'h6
`define DDRCD_CMD_NOP     4'h7

// ****************************************************************
// Decoded command kinds
// ****************************************************************
`define DDRCD_K_NONE      4'h0
`define DDRCD_K_MRS       4'h1
`define DDRCD_K_EMRS      4'h2
`define DDRCD_K_ACT       4'h3
`define DDRCD_K_RD        4'h4
`define DDRCD_K_WR        4'h5
`define DDRCD_K_PRE       4'h6
`define DDRCD_K_PREALL    4'h7
`define DDRCD_K_BST       4'h8
`define DDRCD_K_REF       4'h9
`define DDRCD_K_SREF      4'ha
`define DDRCD_K_PDN       4'hb
`define DDRCD_K_EXIT      4'hc

// ****************************************************************
// Field positions and timing
// ****************************************************************
`define DDRCD_AP_BIT      10
`define DDRCD_COL_W       10
`define DDRCD_BL_HALF     6'h4
`define DDRCD_TWR_NS      15
`define DDRCD_TRP_NS      20
`define DDRCD_CLK_NS      40
// Whole clocks covering the ns figures, rounded up, sized for the counters
`define DDRCD_TWR_CYC     6'h1
`define DDRCD_TRP_CYC     6'h1

`endif

// file: design/ddrcd_sync.v
`timescale 1ns/10ps
module ddrcd_sync (
    input  wire clock,
    input  wire sys_rst,
    input  wire din,
    output reg  dout
);
    reg s1_r;
    reg s2_r;
    reg s3_r;

    // Changes only once stages two and three agree
    always @(posedge clock) begin
        if (sys_rst) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            dout <= 1'b0;
        end else begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                dout <= s3_r;
            end
        end
    end
endmodule

// file: design/ddrcd_buf2.v
`timescale 1ns/10ps
module ddrcd_buf2 (
    input  wire        clock,
    input  wire        sys_rst,
    input  wire        in_valid,
    output wire        in_ready,
    input  wire [29:0] in_data,
    output wire        out_valid,
    input  wire        out_ready,
    output wire [29:0] out_data
);
    reg [29:0] mem_r [0:1];
    reg        wp_r;
    reg        rp_r;
    reg [1:0]  cnt_r;

    assign in_ready  = (cnt_r != 2'h2);
    assign out_valid = (cnt_r != 2'h0);
    assign out_data  = mem_r[rp_r];

    always @(posedge clock) begin
        if (sys_rst) begin
            wp_r  <= 1'b0;
            rp_r  <= 1'b0;
            cnt_r <= 2'h0;
        end else begin
            if (in_valid && in_ready) begin
                mem_r[wp_r] <= in_data;
                wp_r        <= ~wp_r;
            end
            if (out_valid && out_ready) begin
                rp_r <= ~rp_r;
            end
            case ({in_valid && in_ready, out_valid && out_ready})
                2'b10:   cnt_r <= cnt_r + 2'h1;
                2'b01:   cnt_r <= cnt_r - 2'h1;
                default: cnt_r <= cnt_r;
            endcase
        end
    end
endmodule

// file: design/ddrcd_top.v
`timescale 1ns/10ps
`include "ddrcd_defines.vh"
module ddrcd_top (
    input  wire        clock,
    input  wire        sys_rst,
    input  wire        cke,
    input  wire        cs_n,
    input  wire        ras_n,
    input  wire        cas_n,
    input  wire        we_n,
    input  wire [12:0] addr,
    input  wire [1:0]  bank,
    input  wire [1:0]  dm_in,
    input  wire [15:0] dq_in,
    output reg  [15:0] dq_out,
    output reg  [1:0]  dq_oe,
    input  wire [1:0]  dqs_in,
    output reg  [1:0]  dqs_out,
    output reg  [1:0]  dqs_oe,
    input  wire [15:0] rd_data,
    input  wire        rd_valid,
    output reg  [3:0]  cmd_kind,
    output reg         cmd_strobe,
    output reg  [1:0]  cmd_bank,
    output reg  [12:0] cmd_addr,
    output reg         cmd_ap,
    output reg  [14:0] mr_value,
    output reg  [14:0] emr_value,
    output reg  [3:0]  bank_open,
    output reg  [3:0]  bank_locked,
    output reg         low_power,
    output reg         self_refresh,
    output wire        wr_valid,
    input  wire        wr_ready,
    output wire [15:0] wr_data,
    output wire [1:0]  wr_be,
    output wire [9:0]  wr_col,
    output wire [1:0]  wr_bank
);
    // ****************************************************************
    // Command decode
    // ****************************************************************
    function [3:0] decode;
        input       ck_prev;
        input       ck_now;
        input [3:0] code;
        input       bank0;
        input       ap;
        begin
            decode = `DDRCD_K_NONE;
            if (!ck_prev) begin
                decode = ck_now ? `DDRCD_K_EXIT : `DDRCD_K_NONE;
            end else if (!ck_now) begin
                decode = (code == `DDRCD_CMD_REF) ? `DDRCD_K_SREF
                                                  : `DDRCD_K_PDN;
            end else if (!code[3]) begin
                case (code)
                    `DDRCD_CMD_LMR: decode = bank0 ? `DDRCD_K_EMRS
                                                   : `DDRCD_K_MRS;
                    `DDRCD_CMD_REF: decode = `DDRCD_K_REF;
                    `DDRCD_CMD_PRE: decode = ap ? `DDRCD_K_PREALL
                                                : `DDRCD_K_PRE;
                    `DDRCD_CMD_ACT: decode = `DDRCD_K_ACT;
                    `DDRCD_CMD_WR:  decode = `DDRCD_K_WR;
                    `DDRCD_CMD_RD:  decode = `DDRCD_K_RD;
                    `DDRCD_CMD_BST: decode = `DDRCD_K_BST;
                    default:        decode = `DDRCD_K_NONE;
                endcase
            end
        end
    endfunction

    reg        cke_prev_r;
    wire [3:0] kind_nxt = decode(cke_prev_r, cke, {cs_n, ras_n, cas_n, we_n},
                                 bank[0], addr[`DDRCD_AP_BIT]);

    // ****************************************************************
    // Bank state and auto precharge lockout
    // ****************************************************************
    localparam [5:0] RD_LOCK = `DDRCD_BL_HALF + `DDRCD_TRP_CYC;
    localparam [5:0] WR_REC  = `DDRCD_BL_HALF + 6'h1 + `DDRCD_TWR_CYC;
    localparam [5:0] WR_LOCK = WR_REC + `DDRCD_TRP_CYC;

    reg [5:0] lock_cnt_r [0:3];
    reg [3:0] ap_wr_r;

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_bank
            wire hit = (bank == g);
            always @(posedge clock) begin
                if (sys_rst) begin
                    lock_cnt_r[g]  <= 6'h0;
                    ap_wr_r[g]     <= 1'b0;
                    bank_open[g]   <= 1'b0;
                    bank_locked[g] <= 1'b0;
                end else begin
                    if (kind_nxt == `DDRCD_K_ACT && hit) begin
                        bank_open[g] <= 1'b1;
                    end else if (kind_nxt == `DDRCD_K_PREALL) begin
                        bank_open[g] <= 1'b0;
                    end else if (kind_nxt == `DDRCD_K_PRE && hit) begin
                        bank_open[g] <= 1'b0;
                    end
                    if ((kind_nxt == `DDRCD_K_RD || kind_nxt == `DDRCD_K_WR) && hit
                        && addr[`DDRCD_AP_BIT]) begin
                        lock_cnt_r[g]  <= (kind_nxt == `DDRCD_K_RD) ? RD_LOCK
                                                                    : WR_LOCK;
                        ap_wr_r[g]     <= (kind_nxt == `DDRCD_K_WR);
                        bank_locked[g] <= 1'b1;
                    end else if (lock_cnt_r[g] != 6'h0) begin
                        lock_cnt_r[g] <= lock_cnt_r[g] - 6'h1;
                        // Row closes once the half burst has run out for a read, or write recovery for a write
                        // An activate in the same cycle wins over the close
                        if (lock_cnt_r[g] == (ap_wr_r[g] ? WR_LOCK - WR_REC
                                                         : `DDRCD_TRP_CYC)
                            && !(kind_nxt == `DDRCD_K_ACT && hit)) begin
                            bank_open[g] <= 1'b0;
                        end
                        if (lock_cnt_r[g] == 6'h1) begin
                            bank_locked[g] <= 1'b0;
                        end
                    end
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Command outputs, mode registers and power state
    // ****************************************************************
    always @(posedge clock) begin
        if (sys_rst) begin
            cke_prev_r   <= 1'b0;
            cmd_kind     <= `DDRCD_K_NONE;
            cmd_strobe   <= 1'b0;
            cmd_bank     <= 2'h0;
            cmd_addr     <= 13'h0;
            cmd_ap       <= 1'b0;
            mr_value     <= 15'h0;
            emr_value    <= 15'h0;
            low_power    <= 1'b0;
            self_refresh <= 1'b0;
        end else begin
            cke_prev_r <= cke;
            cmd_kind   <= kind_nxt;
            cmd_strobe <= (kind_nxt != `DDRCD_K_NONE);
            if (kind_nxt != `DDRCD_K_NONE) begin
                cmd_bank <= bank;
                cmd_addr <= addr;
                cmd_ap   <= addr[`DDRCD_AP_BIT] &&
                            (kind_nxt == `DDRCD_K_RD || kind_nxt == `DDRCD_K_WR);
            end
            if (kind_nxt == `DDRCD_K_MRS) begin
                mr_value <= {bank, addr};
            end
            if (kind_nxt == `DDRCD_K_EMRS) begin
                emr_value <= {bank, addr};
            end
            if (kind_nxt == `DDRCD_K_SREF || kind_nxt == `DDRCD_K_PDN) begin
                low_power    <= 1'b1;
                self_refresh <= (kind_nxt == `DDRCD_K_SREF);
            end else if (kind_nxt == `DDRCD_K_EXIT) begin
                low_power    <= 1'b0;
                self_refresh <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Write capture on strobe edges, per byte lane
    // ****************************************************************
    wire [1:0] dqs_s;
    reg  [1:0] dqs_d_r;
    reg        wr_act_r;
    reg [9:0]  col_r;
    reg [1:0]  wbank_r;
    reg [15:0] beat_r;
    reg [1:0]  beat_be_r;
    reg        beat_v_r;
    wire       buf_ready;

    // ****************************************************************
    // Data and mask delay matched to the strobe synchroniser
    // ****************************************************************
    // The strobe edge is seen four clocks after the pin moves, so data
    // and mask pass four stages as well; they must hold one clock past
    // the strobe edge, a limit on how short the write data eye may be.
    reg [17:0] din_p1_r;
    reg [17:0] din_p2_r;
    reg [17:0] din_p3_r;
    reg [17:0] din_p4_r;

    always @(posedge clock) begin
        if (sys_rst) begin
            din_p1_r <= 18'h0;
            din_p2_r <= 18'h0;
            din_p3_r <= 18'h0;
            din_p4_r <= 18'h0;
        end else begin
            din_p1_r <= {dm_in, dq_in};
            din_p2_r <= din_p1_r;
            din_p3_r <= din_p2_r;
            din_p4_r <= din_p3_r;
        end
    end

    generate
        for (g = 0; g < 2; g = g + 1) begin : g_lane
            ddrcd_sync u_sync (
                .clock   (clock),
                .sys_rst (sys_rst),
                .din     (dqs_in[g]),
                .dout    (dqs_s[g])
            );
            always @(posedge clock) begin
                if (sys_rst) begin
                    dqs_d_r[g]   <= 1'b0;
                    beat_be_r[g] <= 1'b0;
                end else begin
                    dqs_d_r[g] <= dqs_s[g];
                    // Each edge of a lane's strobe while a write is active takes its byte and mask
                    if (wr_act_r && (dqs_s[g] != dqs_d_r[g])) begin
                        beat_r[8*g +: 8] <= din_p4_r[8*g +: 8];
                        beat_be_r[g]     <= ~din_p4_r[16+g];
                    end
                end
            end
        end
    endgenerate

    // Lane zero paces the beat; lanes are assumed strobed together
    always @(posedge clock) begin
        if (sys_rst) begin
            wr_act_r <= 1'b0;
            col_r    <= 10'h0;
            wbank_r  <= 2'h0;
            beat_v_r <= 1'b0;
        end else begin
            if (kind_nxt == `DDRCD_K_WR) begin
                wr_act_r <= 1'b1;
                col_r    <= addr[`DDRCD_COL_W-1:0];
                wbank_r  <= bank;
            end else if (kind_nxt != `DDRCD_K_NONE) begin
                wr_act_r <= 1'b0;
            end
            beat_v_r <= wr_act_r && (dqs_s[0] != dqs_d_r[0]);
        end
    end

    // A full buffer drops the beat rather than stall a pin-timed link
    ddrcd_buf2 u_buf (
        .clock     (clock),
        .sys_rst   (sys_rst),
        .in_valid  (beat_v_r && (beat_be_r != 2'h0)),
        .in_ready  (buf_ready),
        .in_data   ({wbank_r, col_r, beat_be_r, beat_r}),
        .out_valid (wr_valid),
        .out_ready (wr_ready),
        .out_data  ({wr_bank, wr_col, wr_be, wr_data})
    );

    // ****************************************************************
    // Read drive: strobe toggles with each data word
    // ****************************************************************
    always @(posedge clock) begin
        if (sys_rst) begin
            dq_out  <= 16'h0;
            dq_oe   <= 2'h0;
            dqs_out <= 2'h0;
            dqs_oe  <= 2'h0;
        end else begin
            dq_oe  <= {2{rd_valid}};
            dqs_oe <= {2{rd_valid}};
            if (rd_valid) begin
                dq_out  <= rd_data;
                dqs_out <= ~dqs_out;
            end else begin
                dqs_out <= 2'h0;
            end
        end
    end
endmodule

// file: dv/ddrcd_ctrl_model.sv
`timescale 1ns/10ps
`include "ddrcd_defines.vh"
module ddrcd_ctrl_model (
    input  wire        clock,
    output reg         cke,
    output reg         cs_n,
    output reg         ras_n,
    output reg         cas_n,
    output reg         we_n,
    output reg  [12:0] addr,
    output reg  [1:0]  bank,
    output reg  [1:0]  dm_in,
    output reg  [15:0] dq_in,
    output reg  [1:0]  dqs_in
);
    integer k;
    initial begin
        cke = 1'b0;
        {cs_n, ras_n, cas_n, we_n} = `DDRCD_CMD_NOP;
        addr = 13'h0;
        bank = 2'h0;
        dm_in = 2'h0;
        dq_in = 16'h0;
        dqs_in = 2'h0;
    end
    // ****************************************
    // Command and write burst drivers
    // ****************************************
    task issue(input ck, input [3:0] code, input [1:0] ba, input [12:0] a, input [1:0] dm);
        begin
            @(negedge clock);
            cke = ck;
            {cs_n, ras_n, cas_n, we_n} = code;
            bank = ba;
            addr = a;
            dm_in = dm;
            @(negedge clock);
            {cs_n, ras_n, cas_n, we_n} = `DDRCD_CMD_NOP;
            // Released lines must not keep showing the old operand
            bank = ~ba;
            addr = ~a;
        end
    endtask
    // Strobe idles low between bursts, data sits centred on the strobe edges
    task burst(input integer n, input [63:0] d, input [7:0] m);
        begin
            #7;
            for (k = 0; k < n; k = k + 1) begin
                dq_in = d[16*k +: 16];
                dm_in = m[2*k +: 2];
                #80 dqs_in = ~dqs_in;
                #80;
            end
            dq_in = ~dq_in;
        end
    endtask
endmodule

// file: dv/ddrcd_top_assertions.sv
`timescale 1ns/10ps
`include "ddrcd_defines.vh"
module ddrcd_chk (
    input wire        clock,
    input wire        sys_rst,
    input wire        cke,
    input wire        cs_n,
    input wire        ras_n,
    input wire        cas_n,
    input wire        we_n,
    input wire [12:0] addr,
    input wire [1:0]  bank,
    input wire [3:0]  cmd_kind,
    input wire        cmd_strobe,
    input wire [12:0] cmd_addr,
    input wire        cmd_ap,
    input wire [14:0] mr_value,
    input wire [14:0] emr_value,
    input wire [3:0]  bank_open,
    input wire        low_power,
    input wire        self_refresh,
    input wire        wr_valid,
    input wire [1:0]  wr_be
);
    reg        cke_q;
    reg [14:0] op_q;
    wire       go = cke_q && cke && !cs_n;
    wire [3:0] op = {cs_n, ras_n, cas_n, we_n};
    always @(posedge clock) begin
        cke_q <= sys_rst ? 1'b0 : cke;
        op_q  <= {bank, addr};
    end
    default clocking dc @(posedge clock); endclocking
    default disable iff (sys_rst);
    property p_desel;
        cke_q && cke && cs_n |=> !cmd_strobe;
    endproperty
    a_desel: assert property (p_desel) else $error("strobe on deselect");
    property p_mrs;
        go && op == `DDRCD_CMD_LMR && !bank[0] |=> cmd_strobe && cmd_kind == `DDRCD_K_MRS
            && mr_value == op_q;
    endproperty
    a_mrs: assert property (p_mrs) else $error("mode load wrong");
    property p_emrs;
        go && op == `DDRCD_CMD_LMR && bank[0] |=> cmd_kind == `DDRCD_K_EMRS && emr_value == op_q;
    endproperty
    a_emrs: assert property (p_emrs) else $error("extended load wrong");
    property p_preall;
        go && op == `DDRCD_CMD_PRE && addr[10] |=> cmd_kind == `DDRCD_K_PREALL
            && bank_open == 4'h0;
    endproperty
    a_preall: assert property (p_preall) else $error("all bank precharge wrong");
    property p_rdwr;
        go && (op == `DDRCD_CMD_RD || op == `DDRCD_CMD_WR) |=> cmd_ap == op_q[10]
            && cmd_addr[9:0] == op_q[9:0];
    endproperty
    a_rdwr: assert property (p_rdwr) else $error("column or flag wrong");
    property p_pdn;
        cke_q && !cke |=> low_power || self_refresh;
    endproperty
    a_pdn: assert property (p_pdn) else $error("no low power entry");
    property p_exit;
        !cke_q && cke |=> cmd_strobe && cmd_kind == `DDRCD_K_EXIT ##[0:1] !(low_power || self_refresh);
    endproperty
    a_exit: assert property (p_exit) else $error("no low power exit");
    property p_beat;
        wr_valid |-> wr_be != 2'h0;
    endproperty
    a_beat: assert property (p_beat) else $error("masked beat delivered");
endmodule
bind ddrcd_top ddrcd_chk u_chk (
    .clock        (clock),
    .sys_rst      (sys_rst),
    .cke          (cke),
    .cs_n         (cs_n),
    .ras_n        (ras_n),
    .cas_n        (cas_n),
    .we_n         (we_n),
    .addr         (addr),
    .bank         (bank),
    .cmd_kind     (cmd_kind),
    .cmd_strobe   (cmd_strobe),
    .cmd_addr     (cmd_addr),
    .cmd_ap       (cmd_ap),
    .mr_value     (mr_value),
    .emr_value    (emr_value),
    .bank_open    (bank_open),
    .low_power    (low_power),
    .self_refresh (self_refresh),
    .wr_valid     (wr_valid),
    .wr_be        (wr_be)
);

// file: dv/ddrcd_top_tb_top.sv
`timescale 1ns/10ps
`include "ddrcd_defines.vh"
module ddrcd_top_tb_top;
    reg         clock;
    reg         sys_rst;
    reg  [15:0] rd_data;
    reg         rd_valid;
    reg         wr_ready;
    integer     num_errors;
    integer     compares;
    integer     i;
    wire        cke, cs_n, ras_n, cas_n, we_n, cmd_strobe, cmd_ap;
    wire        low_power, self_refresh, wr_valid;
    wire [12:0] addr, cmd_addr;
    wire [1:0]  bank, dm_in, dqs_in, dq_oe, dqs_oe, dqs_out, wr_be, wr_bank, cmd_bank;
    wire [15:0] dq_in, dq_out, wr_data;
    wire [3:0]  cmd_kind, bank_open, bank_locked;
    wire [14:0] mr_value, emr_value;
    wire [9:0]  wr_col;
    ddrcd_ctrl_model ctl (
        .clock  (clock),
        .cke    (cke),
        .cs_n   (cs_n),
        .ras_n  (ras_n),
        .cas_n  (cas_n),
        .we_n   (we_n),
        .addr   (addr),
        .bank   (bank),
        .dm_in  (dm_in),
        .dq_in  (dq_in),
        .dqs_in (dqs_in)
    );
    ddrcd_top dut (
        .clock        (clock),
        .sys_rst      (sys_rst),
        .cke          (cke),
        .cs_n         (cs_n),
        .ras_n        (ras_n),
        .cas_n        (cas_n),
        .we_n         (we_n),
        .addr         (addr),
        .bank         (bank),
        .dm_in        (dm_in),
        .dq_in        (dq_in),
        .dq_out       (dq_out),
        .dq_oe        (dq_oe),
        .dqs_in       (dqs_in),
        .dqs_out      (dqs_out),
        .dqs_oe       (dqs_oe),
        .rd_data      (rd_data),
        .rd_valid     (rd_valid),
        .cmd_kind     (cmd_kind),
        .cmd_strobe   (cmd_strobe),
        .cmd_bank     (cmd_bank),
        .cmd_addr     (cmd_addr),
        .cmd_ap       (cmd_ap),
        .mr_value     (mr_value),
        .emr_value    (emr_value),
        .bank_open    (bank_open),
        .bank_locked  (bank_locked),
        .low_power    (low_power),
        .self_refresh (self_refresh),
        .wr_valid     (wr_valid),
        .wr_ready     (wr_ready),
        .wr_data      (wr_data),
        .wr_be        (wr_be),
        .wr_col       (wr_col),
        .wr_bank      (wr_bank)
    );
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    task chk(input [63:0] got, input [63:0] exp);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task cmd(input ck, input [3:0] code, input [1:0] ba, input [12:0] a, input [3:0] kind);
        begin
            ctl.issue(ck, code, ba, a, 2'b11);
            chk({cmd_strobe, cmd_kind}, {1'b1, kind});
        end
    endtask
    task pop(input [1:0] be, input [15:0] d);
        begin
            chk({wr_valid, wr_bank, wr_col, wr_be}, {1'b1, 2'h1, 10'h135, be});
            chk(wr_data & {{8{be[1]}}, {8{be[0]}}}, d & {{8{be[1]}}, {8{be[0]}}});
            wr_ready = 1'b1;
            @(negedge clock);
            wr_ready = 1'b0;
            @(negedge clock);
        end
    endtask
    task stop_test;
        begin
            $display("compares %0d num_errors %0d", compares, num_errors);
            if (num_errors == 0 && compares > 0) begin
                $display("All tests passed");
            end else begin
                $display("Some tests failed");
            end
            $finish;
        end
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task t_power;
        begin
            cmd(1'b1, `DDRCD_CMD_NOP, 2'h0, 13'h0, `DDRCD_K_EXIT);
            cmd(1'b0, `DDRCD_CMD_REF, 2'h0, 13'h0, `DDRCD_K_SREF);
            chk(self_refresh, 1'b1);
            cmd(1'b1, `DDRCD_CMD_NOP, 2'h0, 13'h0, `DDRCD_K_EXIT);
            ctl.issue(1'b1, 4'h8, 2'h3, 13'h1fff, 2'b00);
            chk(cmd_strobe, 1'b0);
        end
    endtask
    task t_banks;
        begin
            cmd(1'b1, `DDRCD_CMD_ACT, 2'h2, 13'h1abc, `DDRCD_K_ACT);
            cmd(1'b1, `DDRCD_CMD_ACT, 2'h0, 13'h0042, `DDRCD_K_ACT);
            chk(cmd_bank, 2'h0);
            cmd(1'b1, `DDRCD_CMD_PRE, 2'h0, 13'h0000, `DDRCD_K_PRE);
            ctl.issue(1'b1, `DDRCD_CMD_NOP, 2'h0, 13'h0, 2'b00);
            chk(bank_open, 4'h4);
            cmd(1'b1, `DDRCD_CMD_PRE, 2'h1, 13'h0400, `DDRCD_K_PREALL);
            ctl.issue(1'b1, `DDRCD_CMD_NOP, 2'h0, 13'h0, 2'b00);
            chk(bank_open, 4'h0);
            cmd(1'b1, `DDRCD_CMD_LMR, 2'h2, 13'h1a5c, `DDRCD_K_MRS);
            chk(mr_value, 15'h5a5c);
            cmd(1'b1, `DDRCD_CMD_LMR, 2'h1, 13'h00a3, `DDRCD_K_EMRS);
            chk({emr_value, mr_value}, {15'h20a3, 15'h5a5c});
            cmd(1'b1, `DDRCD_CMD_REF, 2'h0, 13'h0, `DDRCD_K_REF);
            cmd(1'b1, `DDRCD_CMD_BST, 2'h0, 13'h0, `DDRCD_K_BST);
        end
    endtask
    task t_write;
        begin
            cmd(1'b1, `DDRCD_CMD_ACT, 2'h1, 13'h0777, `DDRCD_K_ACT);
            cmd(1'b1, `DDRCD_CMD_WR, 2'h1, 13'h0135, `DDRCD_K_WR);
            chk({cmd_ap, cmd_addr[9:0]}, {1'b0, 10'h135});
            // Receiver stalls so both beats must wait in the buffer
            ctl.burst(2, {16'hc3d2, 16'ha1b4}, {2'b10, 2'b01});
            repeat (8) @(negedge clock);
            pop(2'b10, 16'ha1b4);
            pop(2'b01, 16'hc3d2);
            cmd(1'b1, `DDRCD_CMD_WR, 2'h1, 13'h0535, `DDRCD_K_WR);
            chk(cmd_ap, 1'b1);
            chk({bank_locked, bank_open}, {4'h2, 4'h2});
            ctl.burst(2, {16'h9e0f, 16'h5555}, {2'b00, 2'b11});
            repeat (8) @(negedge clock);
            pop(2'b11, 16'h9e0f);
            chk(wr_valid, 1'b0);
            cmd(1'b1, `DDRCD_CMD_BST, 2'h0, 13'h0, `DDRCD_K_BST);
            repeat (4) @(negedge clock);
            chk(bank_open[1], 1'b0);
            chk(bank_locked, 4'h0);
        end
    endtask
    task t_read;
        begin
            cmd(1'b1, `DDRCD_CMD_ACT, 2'h3, 13'h0100, `DDRCD_K_ACT);
            cmd(1'b1, `DDRCD_CMD_RD, 2'h3, 13'h0407, `DDRCD_K_RD);
            chk(bank_locked, 4'h8);
            rd_data = 16'h6b29;
            rd_valid = 1'b1;
            @(negedge clock);
            rd_valid = 1'b0;
            i = 0;
            while (dq_oe !== 2'b11 && i < 8) begin
                @(negedge clock);
                i = i + 1;
            end
            chk({dqs_oe, dq_out}, {2'b11, 16'h6b29});
            chk({dq_oe, dqs_out}, 4'hf);
            @(negedge clock);
            chk({dq_oe, dqs_oe, dqs_out}, 6'h0);
            repeat (5) @(negedge clock);
            chk({bank_locked, bank_open}, 8'h0);
        end
    endtask
    initial begin
        num_errors = 0;
        compares = 0;
        sys_rst = 1'b1;
        rd_data = 16'h0;
        rd_valid = 1'b0;
        wr_ready = 1'b0;
        repeat (6) @(negedge clock);
        sys_rst = 1'b0;
        t_power;
        t_banks;
        t_write;
        t_read;
        stop_test;
    end
    initial begin
        #200000;
        num_errors = num_errors + 1;
        stop_test;
    end
endmodule
